/* File: rtl/sram_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_host
    import sram_host_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    // user request
    input  wire logic              req_i,
    input  wire logic              req_write_i,
    input  wire logic [ADDR_W-1:0] req_index_i,
    input  wire logic [DATA_W-1:0] req_wdata_i,
    output logic                   req_ready_o,
    output logic                   rd_valid_o,
    output logic      [DATA_W-1:0] rd_data_o,
    // memory pins
    output logic                   select_n_o,
    output logic                   select_p_o,
    output logic                   write_n_o,
    output logic                   gate_n_o,
    output logic      [ADDR_W-1:0] word_index_lines_o,
    input  wire logic [DATA_W-1:0] data_lines_i,
    output logic      [DATA_W-1:0] data_lines_o,
    output logic      [DATA_W-1:0] data_lines_oe_n_o
);
    state_t            state_q, state_d;
    pins_t             pins_q, pins_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    logic [DATA_W-1:0] wdata_q, wdata_d;
    logic              drive_q, drive_d;
    logic              ready_q, ready_d;
    logic              rvalid_q, rvalid_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [DATA_W-1:0] data_sync;
    logic [CNT_W-1:0]  strobe_len_q, strobe_len_d;

    sync2 #(.W(DATA_W)) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .d_i       (data_lines_i),
        .q_o       (data_sync)
    );

    always_comb begin
        state_d  = state_q;
        pins_d   = pins_q;
        cnt_d    = (cnt_q == CNT_ZERO) ? CNT_ZERO : cnt_q - CNT_ONE;
        wdata_d  = wdata_q;
        drive_d  = drive_q;
        ready_d  = 1'b0;
        rvalid_d = 1'b0;
        rdata_d  = rdata_q;
        case (state_q)
            ST_IDLE: begin
                ready_d = 1'b1;
                if (req_i && ready_q) begin
                    ready_d              = 1'b0;
                    pins_d.word_index    = req_index_i;
                    wdata_d              = req_wdata_i;
                    state_d              = req_write_i ? ST_WSET : ST_RSET;
                end
            end
            ST_RSET: begin
                // address settled one cycle ahead of select and gate
                pins_d.select_n = 1'b0;
                pins_d.select_p = 1'b1;
                pins_d.gate_n   = 1'b0;
                cnt_d           = RD_CYC;
                state_d         = ST_READ;
            end
            ST_READ: begin
                if (cnt_q == CNT_ZERO) begin
                    rdata_d  = data_sync;
                    rvalid_d = 1'b1;
                    pins_d   = PINS_IDLE;
                    pins_d.word_index = pins_q.word_index;
                    cnt_d    = GAP_CYC;
                    state_d  = ST_GAP;
                end
            end
            ST_WSET: begin
                // gate stays high, so the memory never drives
                pins_d.select_n = 1'b0;
                pins_d.select_p = 1'b1;
                drive_d         = 1'b1;
                state_d         = ST_WRITE;
            end
            ST_WRITE: begin
                if (!pins_q.write_n) begin
                    if (cnt_q == CNT_ZERO) begin
                        // strobe alone ends the write, select kept
                        pins_d.write_n = 1'b1;
                        state_d        = ST_GAP;
                        cnt_d          = CNT_ONE;
                    end
                end else begin
                    pins_d.write_n = 1'b0;
                    cnt_d          = WR_CYC - CNT_ONE;
                end
            end
            ST_GAP: begin
                if (pins_q.write_n && !pins_q.select_n) begin
                    pins_d   = PINS_IDLE;
                    pins_d.word_index = pins_q.word_index;
                    drive_d  = 1'b0;  // data held one cycle past strobe rise
                end
                if (cnt_q == CNT_ZERO && pins_q.select_n) begin
                    state_d = ST_IDLE;  // deselected between cycles
                end
            end
            default: begin
                state_d = ST_IDLE;
                pins_d  = PINS_IDLE;
                drive_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q  <= ST_IDLE;
            pins_q   <= PINS_IDLE;
            cnt_q    <= CNT_ZERO;
            wdata_q  <= '0;
            drive_q  <= 1'b0;
            ready_q  <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
        end else begin
            state_q  <= state_d;
            pins_q   <= pins_d;
            cnt_q    <= cnt_d;
            wdata_q  <= wdata_d;
            drive_q  <= drive_d;
            ready_q  <= ready_d;
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
        end
    end

    // low time of the strobe in whole cycles, read only by the width check
    always_comb begin
        strobe_len_d = write_n_o ? CNT_ZERO : strobe_len_q + CNT_ONE;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strobe_len_q <= CNT_ZERO;
        end else begin
            strobe_len_q <= strobe_len_d;
        end
    end

    assign select_n_o         = pins_q.select_n;
    assign select_p_o         = pins_q.select_p;
    assign write_n_o          = pins_q.write_n;
    assign gate_n_o           = pins_q.gate_n;
    assign word_index_lines_o = pins_q.word_index;
    assign data_lines_o       = wdata_q;
    assign data_lines_oe_n_o  = {DATA_W{~drive_q}};
    assign req_ready_o        = ready_q;
    assign rd_valid_o         = rvalid_q;
    assign rd_data_o          = rdata_q;

    // write strobe low needs both selects active
    property p_write_selected;
        @(posedge ref_clk_i) disable iff (rst_i)
        !write_n_o |-> (!select_n_o && select_p_o && drive_q);
    endproperty
    a_write_selected: assert property (p_write_selected) else $error("strobe without select");

    property p_no_contention;
        @(posedge ref_clk_i) disable iff (rst_i)
        drive_q |-> gate_n_o && $past(gate_n_o);
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("host drives with gate low");

    property p_strobe_width;
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(write_n_o) |-> (strobe_len_q >= WR_CYC);
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("strobe too short");

    property p_addr_stable_read;
        @(posedge ref_clk_i) disable iff (rst_i)
        $fell(gate_n_o) |-> $stable(word_index_lines_o) && (word_index_lines_o == $past(word_index_lines_o));
    endproperty
    a_addr_stable_read: assert property (p_addr_stable_read) else $error("address moved at select");

    sequence s_read_open;
        $fell(gate_n_o) && !select_n_o;
    endsequence
    property p_read_length;
        @(posedge ref_clk_i) disable iff (rst_i)
        s_read_open |-> !gate_n_o [*2] ##1 !gate_n_o;
    endproperty
    a_read_length: assert property (p_read_length) else $error("read shorter than access");

    property p_release_data;
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(write_n_o) |=> !drive_q && select_n_o;
    endproperty
    a_release_data: assert property (p_release_data) else $error("data not released");

    property p_read_valid;
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(gate_n_o) |-> rd_valid_o;
    endproperty
    a_read_valid: assert property (p_read_valid) else $error("read data not returned");

    property p_ready_idle;
        @(posedge ref_clk_i) disable iff (rst_i)
        req_ready_o |-> select_n_o && write_n_o && gate_n_o && !select_p_o;
    endproperty
    a_ready_idle: assert property (p_ready_idle) else $error("ready while cycle open");
endmodule : sram_host
`default_nettype wire

/* File: rtl/sram_host_pkg.sv */
package sram_host_pkg;

    localparam int ADDR_W      = 15;
    localparam int DATA_W      = 9;
    localparam int CLK_PERIOD_PS = 25000;

    // device timing figures in ns
    localparam int T_RC_NS     = 20;
    localparam int T_AA_NS     = 20;
    localparam int T_DOE_NS    = 9;
    localparam int T_HZOE_NS   = 9;
    localparam int T_WC_NS     = 20;
    localparam int T_PWE_NS    = 15;
    localparam int T_SD_NS     = 10;
    localparam int T_HZWE_NS   = 7;

    function automatic int cyc_min(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_min

    // read settle: address and gate both must have met their access times
    localparam int RD_CYC_I    = cyc_min(T_AA_NS) + 1;
    // write pulse: strobe width, and turnaround plus set-up with gate low
    localparam int WR_CYC_I    = cyc_min((T_PWE_NS > T_HZWE_NS + T_SD_NS) ?
                                         T_PWE_NS : (T_HZWE_NS + T_SD_NS));
    localparam int GAP_CYC_I   = cyc_min(T_HZOE_NS);
    localparam int CNT_W       = 4;
    localparam logic [CNT_W-1:0] RD_CYC  = CNT_W'(RD_CYC_I);
    localparam logic [CNT_W-1:0] WR_CYC  = CNT_W'(WR_CYC_I);
    localparam logic [CNT_W-1:0] GAP_CYC = CNT_W'(GAP_CYC_I);
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RSET  = 3'b001,
        ST_READ  = 3'b010,
        ST_WSET  = 3'b011,
        ST_WRITE = 3'b100,
        ST_GAP   = 3'b101
    } state_t;

    typedef struct packed {
        logic              select_n;
        logic              select_p;
        logic              write_n;
        logic              gate_n;
        logic [ADDR_W-1:0] word_index;
    } pins_t;

    localparam pins_t PINS_IDLE = '{select_n: 1'b1, select_p: 1'b0,
                                    write_n: 1'b1, gate_n: 1'b1,
                                    word_index: '0};

endpackage : sram_host_pkg

/* File: rtl/sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module sync2
    import sram_host_pkg::*;
#(
    parameter int W = DATA_W
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule : sync2
`default_nettype wire

/* File: verif/sram_host_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_host_tb
    import sram_host_pkg::*;
;
    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] idx;
        logic [DATA_W-1:0] dat;
    } row_t;
    logic              ref_clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              req_i = 1'b0;
    logic              req_write_i = 1'b0;
    logic [ADDR_W-1:0] req_index_i = '0;
    logic [DATA_W-1:0] req_wdata_i = '0;
    logic              req_ready_o, rd_valid_o, clash;
    logic              select_n_o, select_p_o, write_n_o, gate_n_o;
    logic [DATA_W-1:0] rd_data_o, bus, data_lines_o, data_lines_oe_n_o;
    logic [ADDR_W-1:0] word_index_lines_o;
    int                miscompares = 0;
    int                num_checks = 0;
    int                cycles = 0;
    row_t rows [8] = '{'{1'b1, 15'h0000, 9'h1FF}, '{1'b1, 15'h7FFF, 9'h0AA},
                       '{1'b0, 15'h0000, 9'h1FF}, '{1'b0, 15'h7FFF, 9'h0AA},
                       '{1'b1, 15'h0000, 9'h100}, '{1'b0, 15'h0000, 9'h100},
                       '{1'b1, 15'h2AAA, 9'h155}, '{1'b0, 15'h2AAA, 9'h155}};
    sram_host dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req_i),
        .req_write_i(req_write_i), .req_index_i(req_index_i), .req_wdata_i(req_wdata_i),
        .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
        .select_n_o(select_n_o), .select_p_o(select_p_o), .write_n_o(write_n_o),
        .gate_n_o(gate_n_o), .word_index_lines_o(word_index_lines_o),
        .data_lines_i(bus), .data_lines_o(data_lines_o),
        .data_lines_oe_n_o(data_lines_oe_n_o));
    sram_mem_model mem (.select_n_i(select_n_o), .select_p_i(select_p_o),
        .write_n_i(write_n_o), .gate_n_i(gate_n_o), .word_index_i(word_index_lines_o),
        .host_data_i(data_lines_o), .host_oe_n_i(data_lines_oe_n_o),
        .wire_o(bus), .clash_o(clash));
    always #12.5 ref_clk_i = ~ref_clk_i;
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic chk9(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk9
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk1
    task automatic chk_idle();
        chk1(select_n_o, 1'b1);
        chk1(select_p_o, 1'b0);
        chk1(write_n_o, 1'b1);
        chk1(gate_n_o, 1'b1);
        chk9(data_lines_oe_n_o, 9'h1FF);
        chk1(req_ready_o, 1'b0);
    endtask : chk_idle
    task automatic issue(input row_t r);
        int n;
        n = 0;
        @(negedge ref_clk_i);
        while (req_ready_o !== 1'b1 && n < 40) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk1(req_ready_o, 1'b1);
        req_i = 1'b1;
        {req_write_i, req_index_i, req_wdata_i} = r;
        @(negedge ref_clk_i);
        req_i = 1'b0;
        if (!r.wr) begin
            n = 0;
            while (rd_valid_o !== 1'b1 && n < 20) begin
                @(negedge ref_clk_i);
                n++;
            end
            chk1(rd_valid_o, 1'b1);
            chk9(rd_data_o, r.dat);
            @(negedge ref_clk_i);
            chk1(rd_valid_o, 1'b0);
        end
    endtask : issue
    initial begin
        repeat (3) @(negedge ref_clk_i);
        chk_idle();
        rst_i = 1'b0;
        foreach (rows[i]) issue(rows[i]);
        // a request while busy must leave the stored word alone
        issue('{1'b1, 15'h0005, 9'h011});
        chk1(req_ready_o, 1'b0);
        @(negedge ref_clk_i);
        req_i = 1'b1;
        {req_write_i, req_index_i, req_wdata_i} = {1'b1, 15'h0005, 9'h033};
        @(negedge ref_clk_i);
        req_i = 1'b0;
        issue('{1'b0, 15'h0005, 9'h011});
        // reset in the middle of a read, then the array must still hold
        issue('{1'b1, 15'h1234, 9'h0C3});
        repeat (8) @(negedge ref_clk_i);
        chk1(req_ready_o, 1'b1);
        req_i = 1'b1;
        {req_write_i, req_index_i, req_wdata_i} = {1'b0, 15'h7FFF, 9'h000};
        @(negedge ref_clk_i);
        req_i = 1'b0;
        @(negedge ref_clk_i);
        chk1(gate_n_o, 1'b0);
        rst_i = 1'b1;
        @(negedge ref_clk_i);
        chk_idle();
        rst_i = 1'b0;
        issue('{1'b0, 15'h1234, 9'h0C3});
        issue('{1'b0, 15'h7FFF, 9'h0AA});
        chk1(clash, 1'b0);
        give_verdict();
    end
endmodule : sram_host_tb
`default_nettype wire

/* File: verif/sram_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_mem_model
    import sram_host_pkg::*;
(
    // memory pins
    input  wire logic              select_n_i,
    input  wire logic              select_p_i,
    input  wire logic              write_n_i,
    input  wire logic              gate_n_i,
    input  wire logic [ADDR_W-1:0] word_index_i,
    input  wire logic [DATA_W-1:0] host_data_i,
    input  wire logic [DATA_W-1:0] host_oe_n_i,
    // resolved wire and fault flag
    output logic      [DATA_W-1:0] wire_o,
    output logic                   clash_o
);
    logic [DATA_W-1:0] mem_q [2**ADDR_W];
    logic [DATA_W-1:0] junk = 9'h0A5;
    logic              sel;
    logic              wr_on;
    logic              rd_on;
    logic              host_on;
    logic              rd_ok = 1'b0;
    logic              clash_q = 1'b0;
    realtime           t_chg = 0;
    assign clash_o = clash_q;
    assign sel     = !select_n_i && select_p_i;
    assign wr_on   = sel && !write_n_i;
    assign rd_on   = sel && write_n_i && !gate_n_i;
    assign host_on = (host_oe_n_i == '0);
    // floating lines keep changing so a stale value never reads as good
    always #10 junk = ~junk;
    always @(rd_on or word_index_i) t_chg = $realtime;
    // worst case access for every path; old data is not kept at all
    always #1 begin
        rd_ok = rd_on && ($realtime - t_chg >= T_AA_NS);
        if (rd_on && host_on) clash_q = 1'b1;
    end
    always @* begin
        wire_o = rd_ok ? mem_q[word_index_i] : (host_on ? host_data_i : junk);
    end
    always @(wr_on or word_index_i or wire_o) begin
        if (wr_on) mem_q[word_index_i] = wire_o;
    end
endmodule : sram_mem_model
`default_nettype wire
